/* testbench/fas_ctrl_model.sv */
// Controller-side model that sequences the flash array control lines
`timescale 1ns/100ps
`default_nettype none
module fas_ctrl_model (
  input  wire logic        clk,
  input  wire logic [15:0] array_dout,
  input  wire logic        array_dout_oe,
  output logic             row_select_on,
  output logic             column_mux_on,
  output logic             amplifier_on,
  output logic             output_drive_on,
  output logic             write_cycle_select,
  output logic             erase_select,
  output logic             whole_array_select,
  output logic             store_pulse,
  output logic             info_block_select,
  output logic [7:0]       array_addr,
  output logic [15:0]      array_din
);
  // ********
  // Waits in us, 2 us above the programmed intervals
  // ********
  localparam int SETUP_US = 7;
  localparam int TOWR_US  = 12;
  localparam int HOLD_US  = 7;
  localparam int BHOLD_US = 5;
  localparam int ERASE_US = 5;
  localparam int RCV_US   = 3;
  localparam int HV_US    = 3000;
  logic [8:0] ln = 9'h000;
  bit         done [512];
  int         hv [16];

  // Order: row, column, amplifier, output, write, erase, whole, store, info
  assign {row_select_on, column_mux_on, amplifier_on, output_drive_on, write_cycle_select,
          erase_select, whole_array_select, store_pulse, info_block_select} = ln;
  initial begin
    array_addr = 8'h00;
    array_din  = 16'h0000;
  end

  task automatic wait_us(input int n);
    repeat (n * fas_pkg::US_CYC) @(posedge clk);
  endtask

  // Read mode; off drops the row or column enable
  task automatic read_word(input logic inf, input logic [7:0] a, input logic [1:0] off,
                           output logic [15:0] d, output logic oe);
    @(posedge clk);
    array_addr <= a;
    ln <= {~off, 6'b110000, inf};
    repeat (3) @(posedge clk);
    d = array_dout;
    oe = array_dout_oe;
    ln <= 9'h000;
    array_addr <= ~a;
  endtask

  // Refuses a second write or an over-long high-voltage total per row
  task automatic write_word(input logic inf, input logic [7:0] a, input logic [15:0] d,
                            input int p);
    if (done[{inf, a}] || hv[{inf, a[7:5]}] + p > HV_US) return;
    done[{inf, a}] = 1'b1;
    hv[{inf, a[7:5]}] += p;
    @(posedge clk);
    array_addr <= a;
    array_din <= d;
    @(posedge clk);
    ln <= {8'b10001000, inf};
    wait_us(SETUP_US);
    ln[1] <= 1'b1;
    wait_us(TOWR_US);
    ln[7] <= 1'b1;
    wait_us(p);
    ln[7] <= 1'b0;
    wait_us(1);
    ln[4] <= 1'b0;
    wait_us(HOLD_US);
    ln <= 9'h000;
    wait_us(RCV_US);
    array_addr <= ~a;
    array_din <= ~d;
  endtask

  task automatic erase(input logic mass, input logic inf, input logic [7:0] a);
    @(posedge clk);
    array_addr <= a;
    @(posedge clk);
    ln <= {5'b10000, 1'b1, mass, 1'b0, inf};
    wait_us(SETUP_US);
    ln[1] <= 1'b1;
    wait_us(ERASE_US);
    ln[3] <= 1'b0;
    wait_us(mass ? BHOLD_US : HOLD_US);
    ln <= 9'h000;
    wait_us(RCV_US);
    array_addr <= ~a;
    foreach (done[k]) begin
      if (mass ? (!k[8] || inf) : (k[8] == inf && k[7:5] == a[7:5])) begin
        done[k] = 1'b0;
        hv[k[8:5]] = 0;
      end
    end
  endtask
endmodule
`default_nettype wire

/* testbench/flash_array_sequencing_tb_top.sv */
// Self-checking bench for the flash array sequencing block
`timescale 1ns/100ps
`default_nettype none
module flash_array_sequencing_tb_top;
  // Run intervals in us; erase and bulk hold shortened to keep the run brief
  localparam logic [31:0] TIM [8] = '{32'h5, 32'h5, 32'h3, 32'hA, 32'h1, 32'h14, 32'h3, 32'h3};
  logic        clk       = 1'b0;
  logic        arst_n    = 1'b0;
  logic        ce        = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  wire logic [31:0] reg_rdata;
  wire logic [15:0] array_dout, array_din;
  wire logic [7:0]  array_addr;
  wire logic        array_dout_oe, row_select_on, column_mux_on, amplifier_on;
  wire logic        output_drive_on, write_cycle_select, erase_select, whole_array_select;
  wire logic        store_pulse, info_block_select;
  logic [15:0] mm [256];
  logic [15:0] im [64];
  int          miscompares = 0;
  int          n_checks    = 0;
  int          cycles      = 0;

  fas_array i_fas_array (
    .clk, .arst_n, .ce, .row_select_on, .column_mux_on, .amplifier_on, .output_drive_on,
    .write_cycle_select, .erase_select, .whole_array_select, .store_pulse, .info_block_select,
    .array_addr, .array_din, .array_dout, .array_dout_oe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );
  fas_ctrl_model i_fas_ctrl_model (
    .clk, .array_dout, .array_dout_oe, .row_select_on, .column_mux_on, .amplifier_on,
    .output_drive_on, .write_cycle_select, .erase_select, .whole_array_select, .store_pulse,
    .info_block_select, .array_addr, .array_din
  );

  // 50 MHz clock
  always #10 clk = ~clk;
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      final_report();
    end
  end

  // ********
  // Checks and bus cycles
  // ********
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    chk32({16'h0, got}, {16'h0, exp});
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  // Strobe starts at the caller's edge, so a read can follow a write with no gap
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  // Cells only clear bits when written
  function automatic logic [15:0] write_cycle_select_result(input logic [15:0] old, input logic [15:0] d);
    return old & d;
  endfunction
  // Pulses below the write pulse register plus margin are refused
  task automatic do_write_cycle_select(input logic inf, input logic [7:0] a, input logic [15:0] d, input int p);
    i_fas_ctrl_model.write_word(inf, a, d, p);
    if (p >= 22) begin
      if (inf) im[a[5:0]] = write_cycle_select_result(im[a[5:0]], d);
      else mm[a] = write_cycle_select_result(mm[a], d);
    end
  endtask
  task automatic do_erase(input logic mass, input logic inf, input logic [7:0] a);
    i_fas_ctrl_model.erase(mass, inf, a);
    foreach (mm[i]) if (mass || (!inf && i[7:5] == a[7:5])) mm[i] = 16'hFFFF;
    foreach (im[i]) if (inf && (mass || i[5] == a[5])) im[i] = 16'hFFFF;
  endtask
  task automatic chk_read(input logic inf, input logic [7:0] a, input logic [1:0] off);
    logic [15:0] d;
    logic        oe;
    i_fas_ctrl_model.read_word(inf, a, off, d, oe);
    chk16({15'h0, oe}, {15'h0, off == 2'b00});
    chk16(d, off == 2'b00 ? (inf ? im[a[5:0]] : mm[a]) : 16'h0);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic [7:0]  a;
    logic [15:0] d;
    v = $urandom(32'h6b55f776);
    foreach (mm[i]) mm[i] = 16'hFFFF;
    foreach (im[i]) im[i] = 16'hFFFF;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      reg_read(i[3:0], v);
      chk32(v, i < 8 ? {8'h00, fas_pkg::RST_TIM[i]} : 32'h0);
    end
    for (int i = 0; i < 10; i++) begin
      w = $urandom();
      reg_write(i < 8 ? i[3:0] : 4'hC, w);
      reg_read(i < 8 ? i[3:0] : 4'hC, v);
      chk32(v, i < 8 ? {8'h00, w[23:0]} : 32'h0);
    end
    foreach (TIM[i]) reg_write(i[3:0], TIM[i]);
    // Clock enable low must freeze the interval registers
    ce <= 1'b0;
    reg_write(4'h0, 32'h000000FF);
    ce <= 1'b1;
    reg_read(4'h0, v);
    chk32(v, TIM[0]);
    chk16(array_dout, 16'h0);
    chk16({15'h0, array_dout_oe}, 16'h0);
    a = 8'($urandom());
    d = 16'($urandom());
    chk_read(1'b0, a, 2'b00);
    do_write_cycle_select(1'b0, a, d, 22);
    do_write_cycle_select(1'b1, {2'b00, a[5:0]}, ~d, 22);
    chk_read(1'b0, a, 2'b00);
    chk_read(1'b1, {2'b00, a[5:0]}, 2'b00);
    chk_read(1'b0, a, 2'b10);
    chk_read(1'b0, a, 2'b01);
    do_write_cycle_select(1'b0, a ^ 8'h01, 16'h0000, 2);
    chk_read(1'b0, a ^ 8'h01, 2'b00);
    reg_read(fas_pkg::OFS_STATUS, v);
    chk32(v & 32'h1F, 32'h1 << fas_pkg::ST_PULSE_SHORT);
    reg_write(fas_pkg::OFS_STATUS, 32'h1F);
    reg_read(fas_pkg::OFS_STATUS, v);
    chk32(v & 32'h1F, 32'h0);
    do_erase(1'b0, 1'b1, {2'b00, a[5:0]});
    chk_read(1'b1, {2'b00, a[5:0]}, 2'b00);
    chk_read(1'b0, a, 2'b00);
    do_write_cycle_select(1'b1, {2'b00, a[5:0]}, d, 22);
    do_erase(1'b1, 1'b0, a);
    chk_read(1'b0, a, 2'b00);
    chk_read(1'b1, {2'b00, a[5:0]}, 2'b00);
    do_write_cycle_select(1'b0, a, ~d, 22);
    do_erase(1'b0, 1'b0, a);
    chk_read(1'b0, a, 2'b00);
    do_write_cycle_select(1'b0, a, d, 22);
    do_erase(1'b1, 1'b1, a);
    chk_read(1'b0, a, 2'b00);
    chk_read(1'b1, {2'b00, a[5:0]}, 2'b00);
    for (int i = 0; i < 3; i++) begin
      a = {i[1:0], 6'($urandom())};
      d = 16'($urandom());
      do_write_cycle_select(i[0], i[0] ? {2'b00, a[5:0]} : a, d, 22);
      chk_read(i[0], i[0] ? {2'b00, a[5:0]} : a, 2'b00);
    end
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/fas_array.sv */
// Flash array behind its control lines, with timing checker registers
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fas_array #(
  parameter int DATA_W     = 16,
  parameter int MAIN_WORDS = 256,
  parameter int INFO_WORDS = 64,
  parameter int PAGE_WORDS = 32,
  parameter int ADDR_W     = $clog2(MAIN_WORDS)
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              row_select_on,
  input  wire logic              column_mux_on,
  input  wire logic              amplifier_on,
  input  wire logic              output_drive_on,
  input  wire logic              write_cycle_select,
  input  wire logic              erase_select,
  input  wire logic              whole_array_select,
  input  wire logic              store_pulse,
  input  wire logic              info_block_select,
  input  wire logic [ADDR_W-1:0] array_addr,
  input  wire logic [DATA_W-1:0] array_din,
  output logic      [DATA_W-1:0] array_dout,
  output logic                   array_dout_oe,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata
);

  localparam int INFO_AW = $clog2(INFO_WORDS);
  localparam int PAGE_AW = $clog2(PAGE_WORDS);
  localparam int CNT_W   = fas_pkg::CNT_W;
  localparam int TICK_W  = $clog2(fas_pkg::US_CYC);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (MAIN_WORDS != (1 << ADDR_W) || INFO_WORDS != (1 << INFO_AW) ||
      PAGE_WORDS != (1 << PAGE_AW) || INFO_WORDS > MAIN_WORDS ||
      PAGE_WORDS > INFO_WORDS || DATA_W > 32 || DATA_W < 1) begin : g_bad_param
    $error("fas_array: sizes must be powers of two, page <= info <= main");
  end

  // ************************************************************
  // Microsecond timebase and edge detection
  // ************************************************************
  logic [TICK_W-1:0] tick_cnt;
  logic              prev_col;
  logic              prev_hv;
  logic              prev_store;
  logic              prev_any;
  logic              prev_erase;

  wire us_tick = (tick_cnt == TICK_W'(fas_pkg::US_CYC - 1));
  wire hv_line = write_cycle_select | erase_select;
  wire any_line = row_select_on | column_mux_on | amplifier_on | output_drive_on |
                  hv_line | whole_array_select | store_pulse;
  wire hv_rise    = hv_line & ~prev_hv;
  wire hv_fall    = ~hv_line & prev_hv;
  wire store_rise = store_pulse & ~prev_store;
  wire store_fall = ~store_pulse & prev_store;
  wire col_rise   = column_mux_on & ~prev_col;
  wire col_fall   = ~column_mux_on & prev_col;
  wire any_rise   = any_line & ~prev_any;

  // Prescaler and line history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt   <= '0;
      prev_col   <= 1'b0;
      prev_hv    <= 1'b0;
      prev_store <= 1'b0;
      prev_any   <= 1'b0;
      prev_erase <= 1'b0;
    end else if (ce) begin
      tick_cnt   <= us_tick ? '0 : tick_cnt + TICK_W'(1);
      prev_col   <= column_mux_on;
      prev_hv    <= hv_line;
      prev_store <= store_pulse;
      prev_any   <= any_line;
      prev_erase <= erase_select;
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  // Read needs every access enable; a missing row, column or output enable blocks data
  wire ctl_read = row_select_on & column_mux_on & amplifier_on & output_drive_on &
                  ~hv_line & ~store_pulse & ~whole_array_select;
  wire ctl_write_cycle_select = row_select_on & write_cycle_select & store_pulse & ~erase_select;
  wire ctl_erase = row_select_on & erase_select & store_pulse & ~write_cycle_select &
                   ~column_mux_on;

  // ************************************************************
  // Interval counters, in microseconds, saturating
  // ************************************************************
  logic [CNT_W-1:0] evt_us;   // Since last edge of write, erase or store
  logic [CNT_W-1:0] hv_us;    // Write or erase line held
  logic [CNT_W-1:0] pulse_us; // Current write pulse held
  logic [CNT_W-1:0] tim [fas_pkg::N_TIM];

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic t);
    sat_inc = (t && v != '1) ? v + CNT_W'(1) : v;
  endfunction

  wire evt_clr = hv_rise | hv_fall | store_rise | store_fall;

  // Granularity is one microsecond, so a measure may read up to 1 us short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_us   <= '0;
      hv_us    <= '0;
      pulse_us <= '0;
    end else if (ce) begin
      evt_us   <= evt_clr ? '0 : sat_inc(evt_us, us_tick);
      hv_us    <= hv_rise ? '0 : sat_inc(hv_us, us_tick & hv_line);
      pulse_us <= col_rise ? '0 : sat_inc(pulse_us, us_tick & column_mux_on);
    end
  end

  // ************************************************************
  // Sequence checks against the interval registers
  // ************************************************************
  logic mass_last;
  logic recovering;

  wire setup_bad   = store_rise & (~hv_line | evt_us < tim[fas_pkg::T_SETUP]);
  wire towrite_bad = col_rise & ctl_write_cycle_select & evt_us < tim[fas_pkg::T_TO_WRITE];
  wire write_cycle_select_commit = col_fall & ctl_write_cycle_select;
  wire pulse_bad   = write_cycle_select_commit & pulse_us < tim[fas_pkg::T_PULSE];
  wire write_cycle_select_ok     = write_cycle_select_commit & ~pulse_bad;
  wire erase_commit = hv_fall & prev_erase & store_pulse & row_select_on;
  wire [CNT_W-1:0] erase_need = whole_array_select ? tim[fas_pkg::T_BULK_CLR]
                                                   : tim[fas_pkg::T_PAGE_CLR];
  wire erase_bad   = erase_commit & hv_us < erase_need;
  wire erase_ok    = erase_commit & ~erase_bad;
  wire [CNT_W-1:0] hold_need = mass_last ? tim[fas_pkg::T_BULK_HOLD]
                                         : tim[fas_pkg::T_HOLD];
  // Dropping store while write or erase is still up is also a hold fault
  wire hold_bad    = store_fall & (hv_line | evt_us < hold_need);
  wire rcv_bad     = any_rise & recovering & evt_us < tim[fas_pkg::T_RECOVERY];

  wire [fas_pkg::N_FLAGS-1:0] flag_set;
  assign flag_set[fas_pkg::ST_SETUP_SHORT]    = setup_bad;
  assign flag_set[fas_pkg::ST_TOWRITE_SHORT]  = towrite_bad;
  assign flag_set[fas_pkg::ST_PULSE_SHORT]    = pulse_bad | erase_bad;
  assign flag_set[fas_pkg::ST_HOLD_SHORT]     = hold_bad;
  assign flag_set[fas_pkg::ST_RECOVERY_SHORT] = rcv_bad;

  // Mass flag latched at erase end picks the hold; recovery runs from store fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mass_last  <= 1'b0;
      recovering <= 1'b0;
    end else if (ce) begin
      if (hv_fall) begin
        mass_last <= prev_erase & whole_array_select;
      end
      if (store_fall) begin
        recovering <= 1'b1;
      end else if (any_rise || evt_us >= tim[fas_pkg::T_RECOVERY]) begin
        recovering <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Storage arrays; erased cells read as all ones
  // ************************************************************
  logic [DATA_W-1:0] main_mem [MAIN_WORDS];
  logic [DATA_W-1:0] info_mem [INFO_WORDS];

  wire [INFO_AW-1:0]        info_idx  = array_addr[INFO_AW-1:0];
  wire [ADDR_W-PAGE_AW-1:0] page_sel  = array_addr[ADDR_W-1:PAGE_AW];
  wire [DATA_W-1:0]         main_word = main_mem[array_addr];
  wire [DATA_W-1:0]         info_word = info_mem[info_idx];

  // Programming only clears bits, so a second write cannot raise a zero
  for (genvar i = 0; i < MAIN_WORDS; i++) begin : g_main
    wire page_hit = (page_sel == (ADDR_W - PAGE_AW)'(i >> PAGE_AW));
    wire clr = erase_ok & (whole_array_select | (~info_block_select & page_hit));
    wire wr  = write_cycle_select_ok & ~info_block_select & (array_addr == ADDR_W'(i));
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        main_mem[i] <= '1;
      end else if (ce && clr) begin
        main_mem[i] <= '1;
      end else if (ce && wr) begin
        main_mem[i] <= main_mem[i] & array_din;
      end
    end
  end

  for (genvar i = 0; i < INFO_WORDS; i++) begin : g_info
    wire page_hit = (page_sel == (ADDR_W - PAGE_AW)'(i >> PAGE_AW));
    wire clr = erase_ok & info_block_select & (whole_array_select | page_hit);
    wire wr  = write_cycle_select_ok & info_block_select & (info_idx == INFO_AW'(i));
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        info_mem[i] <= '1;
      end else if (ce && clr) begin
        info_mem[i] <= '1;
      end else if (ce && wr) begin
        info_mem[i] <= info_mem[i] & array_din;
      end
    end
  end

  // ************************************************************
  // Data output bus
  // ************************************************************
  wire [DATA_W-1:0] next_dout = info_block_select ? info_word : main_word;

  // Bus is released whenever any access enable is missing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      array_dout    <= '0;
      array_dout_oe <= 1'b0;
    end else if (ce) begin
      array_dout    <= ctl_read ? next_dout : '0;
      array_dout_oe <= ctl_read;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  logic [fas_pkg::N_FLAGS-1:0] flags;

  wire tim_sel  = ~reg_addr[3];
  wire stat_sel = (reg_addr == fas_pkg::OFS_STATUS);
  wire [31:0] status_word = {20'h00000, recovering, ctl_erase, ctl_write_cycle_select, ctl_read,
                             3'h0, flags};
  wire [31:0] next_rdata = tim_sel  ? {8'h00, tim[reg_addr[2:0]]} :
                           stat_sel ? status_word : 32'h00000000;
  // Write one to clear; a fault in the same cycle stays set
  wire [fas_pkg::N_FLAGS-1:0] next_flags =
    (flags & ~((reg_wr && stat_sel) ? reg_wdata[fas_pkg::N_FLAGS-1:0] : '0)) | flag_set;

  // Interval registers, one per timed phase
  for (genvar t = 0; t < fas_pkg::N_TIM; t++) begin : g_tim
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        tim[t] <= fas_pkg::RST_TIM[t];
      end else if (ce && reg_wr && tim_sel && reg_addr[2:0] == 3'(t)) begin
        tim[t] <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // Status flags and read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags     <= '0;
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      flags     <= next_flags;
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  // ************************************************************
  // Assertions and covers
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_row_gate: assert property ((ce && !row_select_on) |=> !array_dout_oe)
    else $error("data driven with rows disabled");
  a_col_gate: assert property ((ce && !column_mux_on) |=> !array_dout_oe)
    else $error("data driven with column mux disabled");
  a_out_float: assert property (
      (ce && !output_drive_on) |=> (!array_dout_oe && array_dout == '0))
    else $error("output bus not released");
  a_read_info: assert property (
      (ce && ctl_read && info_block_select) |=>
      (array_dout_oe && array_dout == $past(info_word)))
    else $error("info block read returned wrong word");
  a_read_main: assert property (
      (ce && ctl_read && !info_block_select) |=>
      (array_dout_oe && array_dout == $past(main_word)))
    else $error("main block read returned wrong word");
  a_write_cycle_select_info: assert property (
      (ce && write_cycle_select_ok && info_block_select) |=>
      info_mem[$past(info_idx)] == ($past(info_word) & $past(array_din)))
    else $error("info word program not applied");
  a_mass_both: assert property (
      (ce && erase_ok && whole_array_select && info_block_select) |=>
      (main_mem[0] == '1 && info_mem[0] == '1))
    else $error("mass erase missed a block");
  a_short_pulse: assert property (
      (ce && write_cycle_select_commit && pulse_us < tim[fas_pkg::T_PULSE]) |=>
      (flags[fas_pkg::ST_PULSE_SHORT] && main_mem[$past(array_addr)] == $past(main_word)))
    else $error("short write pulse not refused");
  a_reg_readback: assert property (
      (ce && reg_wr && reg_addr == 4'h0) ##1
      (ce && reg_rd && !reg_wr && reg_addr == 4'h0) |=>
      reg_rdata == {8'h00, $past(reg_wdata[CNT_W-1:0], 2)})
    else $error("interval register readback mismatch");

  c_write_cycle_select: cover property (ce && write_cycle_select_ok);
  c_mass: cover property (ce && erase_ok && whole_array_select);
  c_read: cover property ((ce && ctl_read) ##1 array_dout_oe);
  c_fault: cover property (ce && |flag_set);

endmodule
`default_nettype wire

/* verilog/fas_pkg.sv */
// Constants shared by the flash array sequencing block
// Summary of operation
// - While row_select_on is low every row is disabled.
// - While column_mux_on is low the column multiplexer is disabled.
// - While output_drive_on is low the data output bus floats.
// - Read returns info block when info_block_select is 1, else main memory.
// - Word program writes info block when info_block_select is 1, else main.
// - Page erase hits selected block; mass erase with select 1 clears both blocks.
// - Software-programmable registers hold all eight store, write and clear intervals.
package fas_pkg;

  // ************************************************************
  // Timebase
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 24;

  // ************************************************************
  // Register map (word index on the register port)
  // ************************************************************
  localparam int T_SETUP     = 0; // Store setup, us
  localparam int T_HOLD      = 1; // Store hold, us
  localparam int T_BULK_HOLD = 2; // Bulk store hold, us
  localparam int T_TO_WRITE  = 3; // Store to write pulse, us
  localparam int T_RECOVERY  = 4; // Recovery, us
  localparam int T_PULSE     = 5; // Write pulse, us
  localparam int T_PAGE_CLR  = 6; // Page clear, us
  localparam int T_BULK_CLR  = 7; // Bulk clear, us
  localparam int N_TIM       = 8;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Reset values of the interval registers, in microseconds
  localparam logic [CNT_W-1:0] RST_TIM [N_TIM] = '{
    24'h000005, 24'h000005, 24'h000064, 24'h00000A,
    24'h000001, 24'h000014, 24'h004E20, 24'h0186A0
  };

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int ST_SETUP_SHORT    = 0;
  localparam int ST_TOWRITE_SHORT  = 1;
  localparam int ST_PULSE_SHORT    = 2;
  localparam int ST_HOLD_SHORT     = 3;
  localparam int ST_RECOVERY_SHORT = 4;
  localparam int N_FLAGS           = 5;
  localparam int ST_MODE_READ      = 8;
  localparam int ST_MODE_WRITE_CYCLE_SELECT      = 9;
  localparam int ST_MODE_ERASE     = 10;
  localparam int ST_RECOVERING     = 11;

endpackage
